// ==== hdl/ssmp_pkg.sv ====
// Shared constants and types of the two-wire slave memory port
package ssmp_pkg;
   // Address byte: fixed upper four bits, then bits 3:2 from the select input
   localparam logic [3:0] DEV_ADDR_HI = 4'hA;
   // Command codes carried in the first byte after a write address
   localparam logic [7:0] CMD_BLK_WR = 8'h94;
   localparam logic [7:0] CMD_BLK_RD = 8'h95;
   localparam logic [7:0] CMD_REBOOT = 8'h96;
   localparam logic [7:0] CMD_FSTORE = 8'h97;
   localparam logic [7:0] CMD_EXT_ON = 8'h98;
   localparam logic [7:0] CMD_EXT_OFF = 8'h99;
   localparam logic [7:0] CMD_EE_ON = 8'h9A;
   localparam logic [7:0] CMD_EE_OFF = 8'h9B;
   // Last valid address of each page, where the pointer saturates
   localparam logic [7:0] CFG_LAST = 8'h7D;
   localparam logic [7:0] EXT_LAST = 8'h7F;
   localparam logic [7:0] EE_LAST = 8'hFF;
   // Reboot copies EEPROM from this address through CFG_LAST
   localparam logic [7:0] BOOT_FIRST = 8'h0F;
   // Fault store control register and the stored range in EEPROM
   localparam logic [7:0] FLOG_CTRL_ADDR = 8'h47;
   localparam logic [7:0] FLOG_LAST = 8'h11;
   // Block transfer sizes
   localparam logic [7:0] BLK_MAX = 8'h10;
   localparam logic [7:0] BLK_RD_COUNT = 8'h10;
   // EEPROM write time and its count of 8 ns clock cycles (rounded up)
   localparam int CLK_PERIOD_NS = 8;
   localparam int EE_WR_TIME_NS = 1000;
   localparam int EE_WR_CYC = (EE_WR_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam logic [7:0] EE_WR_CYCLES = 8'(EE_WR_CYC);

   typedef enum logic [2:0] {
      ST_IDLE = 3'b000,
      ST_RX = 3'b001,
      ST_RX_ACK = 3'b010,
      ST_TX = 3'b011,
      ST_TX_ACK = 3'b100,
      ST_WAIT = 3'b101
   } ssmp_state_e;

   typedef enum logic [2:0] {
      RL_ADDR = 3'b000,
      RL_CMD = 3'b001,
      RL_COUNT = 3'b010,
      RL_BLK = 3'b011,
      RL_DATA = 3'b100,
      RL_NONE = 3'b101
   } ssmp_role_e;

   typedef enum logic [1:0] {
      PG_DEF = 2'b00,
      PG_EXT = 2'b01,
      PG_EE = 2'b10
   } ssmp_page_e;

   typedef enum logic [1:0] {
      OP_RD = 2'b00,
      OP_WR = 2'b01,
      OP_BOOT = 2'b10,
      OP_FLOG = 2'b11
   } ssmp_op_e;
endpackage

// ==== hdl/ssmp_smbus_slave.sv ====
// Two-wire slave engine on the link clock with its memories on mclk

// How it works
// RQ1 - Data change while clock high is START/STOP
// RQ2 - START and repeated START restart framing alike
// RQ3 - STOP honoured anywhere except START's high pulse
// RQ4 - Acknowledge received bytes by pulling data low
// RQ5 - Transmitter samples master acknowledge slot
// RQ6 - Busy or illegal command byte gets NACK
// RQ7 - Select input sets two slave address bits
// RQ8 - Single byte loads pointer; illegal codes NACKed
// RQ9 - Block write and block read codes acknowledged
// RQ10 - STOP before acknowledge leaves pointer unchanged
// RQ11 - Plain read returns pointer byte then increments
// RQ12 - Master reads one byte via repeated START
// RQ13 - Write byte stores only at valid address
// RQ14 - Invalid read address NACKed, pointer kept
// RQ15 - Reboot command copies EEPROM into default page
// RQ16 - Fault store command saves per control register
// RQ17 - Commands select or leave the extended page
// RQ18 - EEPROM page command maps all addresses
// RQ19 - Master primes EEPROM reads with dummy read
// RQ20 - Block write count 1..16, each byte acknowledged
// RQ21 - Block write pointer saturates at page end
// RQ22 - Refused block write code keeps pointer
// RQ23 - Block read returns count 16 then data
// RQ24 - Reset and reboot return to default page
module ssmp_smbus_slave import ssmp_pkg::*; (
   // System clock and reset
   input wire logic mclk_i,
   input wire logic nrst_i,
   // Link side: sampling clock, bus pins, address select code
   input wire logic lclk_i,
   input wire logic scl_i,
   input wire logic sda_i,
   input wire logic [1:0] bus_address_select_i,
   // Open-drain data pin and busy status
   output logic sda_o,
   output logic sda_oe_n_o,
   output logic busy_o
);

   // ****************************************
   // Helpers
   // ****************************************
   function automatic logic [7:0] page_last(input ssmp_page_e p);
      page_last = (p == PG_EE) ? EE_LAST :
                  ((p == PG_EXT) ? EXT_LAST : CFG_LAST);
   endfunction

   function automatic logic [7:0] sat_inc(input logic [7:0] a,
                                          input ssmp_page_e p);
      sat_inc = (a >= page_last(p)) ? page_last(p) : a + 8'h01;
   endfunction

   // ****************************************
   // Link domain declarations
   // ****************************************
   logic scl_m, scl_s, scl_d;
   logic sda_m, sda_s, sda_d;
   logic [1:0] asel_m, asel_s;
   logic busy_m, busy_s;
   logic ak_m, ak_s, ak_d;
   ssmp_state_e state;
   ssmp_role_e role;
   ssmp_page_e page;
   logic [7:0] shift, txbyte, ptr, rbyte;
   logic [3:0] bitcnt;
   logic [4:0] blk_left;
   logic start_hi, acked, go_tx, blk_rd, first_cnt, is_cnt;
   logic pend_rd, pend_wr, pend_boot, pend_flog, hs_busy, req_tgl;
   logic [7:0] wr_addr, wr_data;
   ssmp_page_e wr_page;
   ssmp_op_e op;
   logic [7:0] op_addr, op_wdata;
   ssmp_page_e op_page;
   // mclk domain items read by the link side after a handshake
   logic [7:0] rd_result;
   logic ak_tgl;

   wire scl_rise = scl_s & ~scl_d;
   wire scl_fall = ~scl_s & scl_d;
   wire start_c = scl_s & scl_d & sda_d & ~sda_s; // see RQ1
   wire stop_c = scl_s & scl_d & ~sda_d & sda_s; // see RQ1
   wire stop_ok = stop_c & ~start_hi; // see RQ3
   wire ack_edge = ak_s ^ ak_d;
   wire [7:0] tx_first = first_cnt ? BLK_RD_COUNT : rbyte; // see RQ23
   wire addr_ok = (shift <= page_last(page)); // see RQ8

   // ****************************************
   // Link domain synchronisers
   // ****************************************
   // Pins and mclk levels pass two flops; the third flop feeds edges only
   always_ff @(posedge lclk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         scl_m <= 1'b1;
         scl_s <= 1'b1;
         scl_d <= 1'b1;
         sda_m <= 1'b1;
         sda_s <= 1'b1;
         sda_d <= 1'b1;
         asel_m <= 2'h0;
         asel_s <= 2'h0;
         busy_m <= 1'b0;
         busy_s <= 1'b0;
         ak_m <= 1'b0;
         ak_s <= 1'b0;
         ak_d <= 1'b0;
      end else begin
         scl_m <= scl_i;
         scl_s <= scl_m;
         scl_d <= scl_s;
         sda_m <= sda_i;
         sda_s <= sda_m;
         sda_d <= sda_s;
         asel_m <= bus_address_select_i;
         asel_s <= asel_m;
         busy_m <= busy_o;
         busy_s <= busy_m;
         ak_m <= ak_tgl;
         ak_s <= ak_m;
         ak_d <= ak_s;
      end
   end

   // ****************************************
   // Link domain byte engine
   // ****************************************
   // Launch is written first so a flag set by the engine in the same
   // cycle survives and the operation simply runs again later.
   always_ff @(posedge lclk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         state <= ST_IDLE;
         role <= RL_ADDR;
         page <= PG_DEF; // see RQ24
         shift <= 8'h00;
         txbyte <= 8'h00;
         ptr <= 8'h00;
         rbyte <= 8'h00;
         bitcnt <= 4'h0;
         blk_left <= 5'h00;
         start_hi <= 1'b0;
         acked <= 1'b0;
         go_tx <= 1'b0;
         blk_rd <= 1'b0;
         first_cnt <= 1'b0;
         is_cnt <= 1'b0;
         pend_rd <= 1'b1;
         pend_wr <= 1'b0;
         pend_boot <= 1'b0;
         pend_flog <= 1'b0;
         hs_busy <= 1'b0;
         req_tgl <= 1'b0;
         wr_addr <= 8'h00;
         wr_data <= 8'h00;
         wr_page <= PG_DEF;
         op <= OP_RD;
         op_addr <= 8'h00;
         op_wdata <= 8'h00;
         op_page <= PG_DEF;
         sda_oe_n_o <= 1'b1;
         sda_o <= 1'b0;
      end else begin
         sda_o <= 1'b0;
         // Handshake toward mclk: fields stay put until the answer toggles
         if (hs_busy) begin
            if (ack_edge) begin
               hs_busy <= 1'b0;
               if (op == OP_RD) begin
                  rbyte <= rd_result;
               end
            end
         end else if (pend_boot | pend_flog | pend_wr | pend_rd) begin
            hs_busy <= 1'b1;
            req_tgl <= ~req_tgl;
            op_page <= page;
            op_addr <= ptr;
            if (pend_boot) begin
               op <= OP_BOOT;
               pend_boot <= 1'b0;
            end else if (pend_flog) begin
               op <= OP_FLOG;
               pend_flog <= 1'b0;
            end else if (pend_wr) begin
               op <= OP_WR;
               op_addr <= wr_addr;
               op_wdata <= wr_data;
               op_page <= wr_page;
               pend_wr <= 1'b0;
            end else begin
               op <= OP_RD;
               pend_rd <= 1'b0;
            end
         end
         // Bus framing
         if (start_c) begin // see RQ2
            state <= ST_RX;
            role <= RL_ADDR;
            bitcnt <= 4'h0;
            start_hi <= 1'b1;
            sda_oe_n_o <= 1'b1;
         end else if (stop_ok) begin // see RQ3
            state <= ST_IDLE;
            blk_rd <= 1'b0;
            sda_oe_n_o <= 1'b1;
         end else begin
            if (scl_fall) begin
               start_hi <= 1'b0;
            end
            case (state)
               ST_RX: begin
                  if (scl_rise) begin
                     shift <= {shift[6:0], sda_s};
                     bitcnt <= bitcnt + 4'h1;
                  end else if (scl_fall && bitcnt == 4'h8) begin
                     bitcnt <= 4'h0;
                     state <= ST_RX_ACK;
                     acked <= 1'b0;
                     go_tx <= 1'b0;
                     case (role)
                        RL_ADDR: begin
                           if (shift[7:2] == {DEV_ADDR_HI, asel_s}) begin // see RQ7
                              acked <= 1'b1;
                              go_tx <= shift[0];
                              role <= RL_CMD;
                              if (shift[0]) begin
                                 first_cnt <= blk_rd; // see RQ23
                              end else begin
                                 blk_rd <= 1'b0;
                              end
                           end
                        end
                        RL_CMD: begin
                           // Pointer and page change only as the ACK goes out
                           if (!busy_s) begin // see RQ6, RQ22
                              acked <= 1'b1;
                              role <= RL_NONE;
                              case (shift)
                                 CMD_BLK_WR: role <= RL_COUNT; // see RQ9
                                 CMD_BLK_RD: blk_rd <= 1'b1; // see RQ9
                                 CMD_REBOOT: begin
                                    pend_boot <= 1'b1; // see RQ15
                                    page <= PG_DEF; // see RQ24
                                 end
                                 CMD_FSTORE: pend_flog <= 1'b1; // see RQ16
                                 CMD_EXT_ON: page <= PG_EXT; // see RQ17
                                 CMD_EXT_OFF: page <= PG_DEF; // see RQ17
                                 CMD_EE_ON: page <= PG_EE; // see RQ18
                                 CMD_EE_OFF: page <= PG_DEF; // see RQ18
                                 default: begin
                                    if (addr_ok) begin // see RQ8, RQ10
                                       ptr <= shift;
                                       pend_rd <= 1'b1;
                                       role <= RL_DATA;
                                    end else begin
                                       acked <= 1'b0; // see RQ14
                                    end
                                 end
                              endcase
                           end
                        end
                        RL_COUNT: begin
                           if (shift != 8'h00 && shift <= BLK_MAX) begin // see RQ20
                              acked <= 1'b1;
                              blk_left <= shift[4:0];
                              role <= RL_BLK;
                           end
                        end
                        RL_BLK: begin
                           if (blk_left != 5'h00) begin // see RQ20
                              acked <= 1'b1;
                              blk_left <= blk_left - 5'h01;
                              wr_addr <= ptr;
                              wr_data <= shift;
                              wr_page <= page;
                              pend_wr <= 1'b1;
                              ptr <= sat_inc(ptr, page); // see RQ21
                              pend_rd <= 1'b1;
                           end
                        end
                        RL_DATA: begin
                           acked <= 1'b1; // see RQ13
                           wr_addr <= ptr;
                           wr_data <= shift;
                           wr_page <= page;
                           pend_wr <= 1'b1;
                           pend_rd <= 1'b1;
                           role <= RL_NONE;
                        end
                        default: acked <= 1'b0;
                     endcase
                  end
               end
               ST_RX_ACK: begin
                  if (scl_fall) begin
                     sda_oe_n_o <= 1'b1;
                     if (!acked) begin
                        state <= ST_WAIT;
                     end else if (go_tx) begin
                        state <= ST_TX;
                        sda_oe_n_o <= tx_first[7];
                        txbyte <= {tx_first[6:0], 1'b0};
                        is_cnt <= first_cnt;
                        first_cnt <= 1'b0;
                        bitcnt <= 4'h1;
                     end else begin
                        state <= ST_RX;
                     end
                  end else if (acked) begin
                     sda_oe_n_o <= 1'b0; // see RQ4
                  end
               end
               ST_TX: begin
                  if (scl_fall) begin
                     if (bitcnt == 4'h8) begin
                        sda_oe_n_o <= 1'b1;
                        state <= ST_TX_ACK;
                        bitcnt <= 4'h0;
                        if (!is_cnt) begin
                           ptr <= sat_inc(ptr, page); // see RQ11
                           pend_rd <= 1'b1;
                        end
                     end else begin
                        sda_oe_n_o <= txbyte[7];
                        txbyte <= {txbyte[6:0], 1'b0};
                        bitcnt <= bitcnt + 4'h1;
                     end
                  end
               end
               ST_TX_ACK: begin
                  if (scl_rise && sda_s) begin
                     state <= ST_WAIT; // see RQ5, RQ11
                  end else if (scl_fall) begin
                     state <= ST_TX; // see RQ23
                     sda_oe_n_o <= tx_first[7];
                     txbyte <= {tx_first[6:0], 1'b0};
                     is_cnt <= first_cnt;
                     first_cnt <= 1'b0;
                     bitcnt <= 4'h1;
                  end
               end
               default: begin
                  state <= state; // Idle or waiting for the next frame
               end
            endcase
         end
      end
   end

   // ****************************************
   // System domain
   // ****************************************
   logic rq_m, rq_s, rq_d, job, booting, flogging;
   logic [7:0] ee_cnt, boot_idx, flog_idx;
   logic [7:0] cfg_mem [0:127];
   logic [7:0] ext_mem [0:127];
   logic [7:0] ee_mem [0:255];
   wire busy_c = (ee_cnt != 8'h00) | booting | flogging;
   wire run = job & ~busy_c;
   wire wr_cfg = run & (op == OP_WR) & (op_page == PG_DEF);
   wire wr_ext = run & (op == OP_WR) & (op_page == PG_EXT);
   wire wr_ee = run & (op == OP_WR) & (op_page == PG_EE);

   // Request toggle sync; a job waits while the memory is busy
   always_ff @(posedge mclk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         rq_m <= 1'b0;
         rq_s <= 1'b0;
         rq_d <= 1'b0;
         job <= 1'b0;
         ak_tgl <= 1'b0;
         rd_result <= 8'h00;
      end else begin
         rq_m <= req_tgl;
         rq_s <= rq_m;
         rq_d <= rq_s;
         if (rq_s ^ rq_d) begin
            job <= 1'b1;
         end else if (run) begin
            job <= 1'b0;
            ak_tgl <= ~ak_tgl;
            if (op == OP_RD) begin
               case (op_page)
                  PG_EXT: rd_result <= ext_mem[op_addr[6:0]];
                  PG_EE: rd_result <= ee_mem[op_addr];
                  default: rd_result <= cfg_mem[op_addr[6:0]];
               endcase
            end
         end
      end
   end

   // Busy sequencing: EEPROM write time, reboot copy, fault store copy
   always_ff @(posedge mclk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         ee_cnt <= 8'h00;
         booting <= 1'b0;
         flogging <= 1'b0;
         boot_idx <= 8'h00;
         flog_idx <= 8'h00;
         busy_o <= 1'b0;
      end else begin
         busy_o <= busy_c; // see RQ6
         if (ee_cnt != 8'h00) begin
            ee_cnt <= ee_cnt - 8'h01;
         end else if (wr_ee) begin
            ee_cnt <= EE_WR_CYCLES;
         end
         if (run && op == OP_BOOT) begin
            booting <= 1'b1; // see RQ15
            boot_idx <= BOOT_FIRST;
         end else if (booting) begin
            boot_idx <= boot_idx + 8'h01;
            booting <= (boot_idx != CFG_LAST);
         end
         // Nothing is stored when neither source is chosen
         if (run && op == OP_FLOG) begin
            flogging <= (cfg_mem[FLOG_CTRL_ADDR[6:0]][1:0] != 2'b00); // see RQ16
            flog_idx <= 8'h00;
         end else if (flogging) begin
            flog_idx <= flog_idx + 8'h01;
            flogging <= (flog_idx != FLOG_LAST);
         end
      end
   end

   // Memories: one write port each, index selects the entry
   always_ff @(posedge mclk_i) begin
      if (wr_cfg) begin
         cfg_mem[op_addr[6:0]] <= op_wdata; // see RQ13
      end else if (booting) begin
         cfg_mem[boot_idx[6:0]] <= ee_mem[boot_idx]; // see RQ15
      end
      if (wr_ext) begin
         ext_mem[op_addr[6:0]] <= op_wdata;
      end
      if (wr_ee) begin
         ee_mem[op_addr] <= op_wdata;
      end else if (flogging) begin
         ee_mem[flog_idx] <= ext_mem[flog_idx[6:0]];
      end
   end

endmodule // ssmp_smbus_slave

// ==== tb/ssmp_chk.sv ====
// Port checker of the two-wire slave memory port
module ssmp_chk (
   // Clocks and reset
   input wire logic mclk_i,
   input wire logic nrst_i,
   input wire logic lclk_i,
   // Watched pins
   input wire logic scl_i,
   input wire logic sda_i,
   input wire logic [1:0] bus_address_select_i,
   input wire logic sda_o,
   input wire logic sda_oe_n_o,
   input wire logic busy_o
);
   timeunit 1ns;
   timeprecision 100ps;
   // ****
   // Run lengths
   // ****
   logic [3:0] hi_cnt;
   logic [6:0] lo_cnt;
   logic [11:0] bz_cnt;
   // Saturate so a long idle never wraps back to zero
   always_ff @(posedge lclk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         hi_cnt <= 4'h0;
         lo_cnt <= 7'h00;
      end else begin
         hi_cnt <= scl_i ? hi_cnt + 4'(hi_cnt != 4'hF) : 4'h0;
         lo_cnt <= !sda_oe_n_o ? lo_cnt + 7'(lo_cnt != 7'h7F) : 7'h00;
      end
   end
   // Busy length, held apart from the link logic
   always_ff @(posedge mclk_i or negedge nrst_i) begin
      if (!nrst_i) bz_cnt <= 12'h000;
      else bz_cnt <= busy_o ? bz_cnt + 12'(bz_cnt != 12'hFFF) : 12'h000;
   end
   // ****
   // Properties
   // ****
   sda_fixed_a: assert property (@(posedge lclk_i)
      disable iff (!nrst_i) sda_o == 1'b0) else $error("data out not low");
   drive_edge_a: assert property (@(posedge lclk_i)
      disable iff (!nrst_i) $changed(sda_oe_n_o) |->
      !(scl_i && $past(scl_i) && $past(scl_i, 2))) else $error("sda moved");
   reset_rel_a: assert property (@(posedge lclk_i)
      disable iff (!nrst_i) nrst_i && !$past(nrst_i) |->
      sda_oe_n_o && !busy_o) else $error("not idle after reset");
   ack_hold_a: assert property (@(posedge lclk_i)
      disable iff (!nrst_i) $fell(sda_oe_n_o) |-> !sda_oe_n_o [*4])
      else $error("drive too short");
   idle_free_a: assert property (@(posedge lclk_i)
      disable iff (!nrst_i) hi_cnt >= 4'h6 |-> sda_oe_n_o)
      else $error("line held while idle");
   drive_max_a: assert property (@(posedge lclk_i)
      disable iff (!nrst_i) lo_cnt < 7'h64) else $error("line held too long");
   busy_min_a: assert property (@(posedge mclk_i)
      disable iff (!nrst_i) $rose(busy_o) |-> busy_o [*8])
      else $error("busy too short");
   busy_max_a: assert property (@(posedge mclk_i)
      disable iff (!nrst_i) bz_cnt < 12'hFA0) else $error("busy too long");
   ack_c: cover property (@(posedge lclk_i) $fell(sda_oe_n_o));
   busy_c: cover property (@(posedge mclk_i) $rose(busy_o));
   idle_c: cover property (@(posedge lclk_i) hi_cnt == 4'hF);
endmodule // ssmp_chk

bind ssmp_smbus_slave ssmp_chk chk_u (.mclk_i(mclk_i), .nrst_i(nrst_i),
   .lclk_i(lclk_i), .scl_i(scl_i), .sda_i(sda_i),
   .bus_address_select_i(bus_address_select_i), .sda_o(sda_o),
   .sda_oe_n_o(sda_oe_n_o), .busy_o(busy_o));

// ==== tb/ssmp_mst_mdl.sv ====
// Bus master model that frames transfers on the two-wire link
module ssmp_mst_mdl #(
   parameter int HP = 88
) (
   // Pacing clock and resolved data line
   input wire logic mclk_i,
   input wire logic sda_i,
   // Bus clock and data pull-down
   output logic scl_o,
   output logic sda_low_o
);
   timeunit 1ns;
   timeprecision 100ps;
   // ****
   // Bus sequences
   // ****
   initial begin
      scl_o = 1'b1;
      sda_low_o = 1'b0;
   end
   task automatic gap(input int n);
      repeat (n) @(posedge mclk_i);
   endtask
   // Data moves only mid-low, so no false START or STOP is seen
   task automatic bit_io(input logic b, output logic r);
      gap(HP / 2);
      sda_low_o <= !b;
      gap(HP / 2);
      scl_o <= 1'b1;
      gap(HP / 2);
      r = sda_i;
      gap(HP / 2);
      scl_o <= 1'b0;
   endtask
   task automatic stop();
      gap(HP / 2);
      sda_low_o <= 1'b1;
      gap(HP / 2);
      scl_o <= 1'b1;
      gap(HP);
      sda_low_o <= 1'b0;
      gap(HP);
   endtask
   // START and repeated START share one sequence
   task automatic strt();
      gap(HP / 2);
      sda_low_o <= 1'b0;
      gap(HP / 2);
      scl_o <= 1'b1;
      gap(HP);
      sda_low_o <= 1'b1;
      gap(HP);
      scl_o <= 1'b0;
   endtask
   // Send n bits MSB first; only a whole byte gets its ninth clock
   task automatic wr_byte(input logic [7:0] d, input int n, output logic a);
      logic r;
      a = 1'b0;
      for (int i = 7; i > 7 - n; i--) bit_io(d[i], r);
      if (n == 8) begin
         bit_io(1'b1, r);
         a = !r;
      end
   endtask
   // The master acknowledges or refuses each byte it reads
   task automatic rd_byte(input logic mack, output logic [7:0] d);
      logic r;
      for (int i = 7; i >= 0; i--) bit_io(1'b1, d[i]);
      bit_io(!mack, r);
   endtask
endmodule // ssmp_mst_mdl

// ==== tb/tb_top.sv ====
// Self-checking bench of the two-wire slave memory port
module tb_top import ssmp_pkg::*; ();
   timeunit 1ns;
   timeprecision 100ps;
   // ****
   // Bench
   // ****
   logic mclk_i = 1'b0;
   logic lclk_i = 1'b0;
   logic nrst_i = 1'b0;
   logic [1:0] sel = 2'h0;
   logic scl, mst_low, sda_w, sda_o, sda_oe_n_o, busy_o, ack;
   logic [7:0] rd;
   logic [7:0] d [4];
   int mismatches = 0, n_checks = 0, rises = 0;
   // Link clock offset so its edges never meet the system clock
   always #4 mclk_i = ~mclk_i;
   initial begin
      #3.3;
      forever #80 lclk_i = ~lclk_i;
   end
   // Pull-up wins unless a party pulls the line low
   assign sda_w = !mst_low && (sda_oe_n_o || sda_o);
   always @(posedge busy_o) rises++;
   ssmp_smbus_slave dut_u (.mclk_i(mclk_i), .nrst_i(nrst_i),
      .lclk_i(lclk_i), .scl_i(scl), .sda_i(sda_w),
      .bus_address_select_i(sel), .sda_o(sda_o),
      .sda_oe_n_o(sda_oe_n_o), .busy_o(busy_o));
   ssmp_mst_mdl mst_u (.mclk_i(mclk_i), .sda_i(sda_w), .scl_o(scl),
      .sda_low_o(mst_low));
   // Address byte for the present select code, random don't-care bit
   function automatic logic [7:0] ab(input logic rw);
      return {DEV_ADDR_HI, sel, 1'($urandom), rw};
   endfunction
   // Four-byte block from 7Bh: late bytes pile onto the last address
   function automatic logic [7:0] exp_at(input logic [7:0] loc);
      logic [7:0] e;
      logic [7:0] p;
      e = 8'h00;
      for (int j = 0; j < 4; j++) begin
         p = (8'h7B + j > CFG_LAST) ? CFG_LAST : 8'(8'h7B + j);
         if (p == loc) e = d[j];
      end
      return e;
   endfunction
   task automatic chk_bit(input logic got, input logic exp);
      chk_byte({7'h00, got}, {7'h00, exp});
   endtask
   task automatic chk_byte(input logic [7:0] got, input logic [7:0] exp);
      n_checks++;
      if (got !== exp) begin
         mismatches++;
         $display("CHECK FAILED t=%0t got %0h exp %0h", $time, got, exp);
      end
   endtask
   // One framed write; bytes after the refused one are not sent
   task automatic send(input logic [7:0] q [$], input int nak);
      logic a;
      mst_u.strt();
      foreach (q[i]) begin
         if (i <= nak) begin
            mst_u.wr_byte(q[i], 8, a);
            chk_bit(a, logic'(i != nak));
         end
      end
      mst_u.stop();
   endtask
   task automatic rcv(input logic [7:0] exp);
      mst_u.strt();
      mst_u.wr_byte(ab(1'b1), 8, ack);
      chk_bit(ack, 1'b1);
      mst_u.rd_byte(1'b0, rd);
      mst_u.stop();
      chk_byte(rd, exp);
   endtask
   task automatic rdb(input logic [7:0] a, exp);
      mst_u.strt();
      mst_u.wr_byte(ab(0), 8, ack);
      mst_u.wr_byte(a, 8, ack);
      chk_bit(ack, 1'b1);
      rcv(exp);
   endtask
   task automatic wbusy();
      for (int i = 0; i < 5000 && busy_o !== 1'b0; i++) @(posedge mclk_i);
      chk_bit(busy_o, 1'b0);
   endtask
   // New select code for each test; the settle time is a whole START
   task automatic note(input string s);
      $display("Test %s done", s);
      @(posedge mclk_i);
      sel <= 2'($urandom);
      @(posedge mclk_i);
   endtask
   task automatic conclude();
      $display("Checks %0d, mismatches %0d", n_checks, mismatches);
      if (mismatches == 0 && n_checks > 0) begin
         $display("Finished cleanly");
      end else begin
         $display("Finished with errors");
      end
      $finish;
   endtask
   initial begin
      #2_000_000;
      mismatches++;
      $display("Watchdog expired");
      conclude();
   end
   initial begin
      void'($urandom(32'h5221DBEB));
      foreach (d[i]) d[i] = 8'($urandom);
      repeat (3) @(posedge mclk_i);
      repeat (2) @(posedge lclk_i);
      @(posedge mclk_i);
      nrst_i <= 1'b1;
      repeat (5) @(posedge lclk_i);
      note("reset");
      send('{{DEV_ADDR_HI, ~sel, 2'h0}}, 0);
      send('{ab(0), 8'h7B}, 9);
      send('{ab(0), CMD_BLK_WR, 8'h04, d[0], d[1], d[2], d[3]}, 9);
      send('{ab(0), 8'h7B}, 9);
      for (int i = 0; i < 3; i++) rcv(exp_at(8'(8'h7B + i)));
      send('{ab(0), CMD_BLK_WR, BLK_MAX + 8'h01}, 2);
      note("block write");
      send('{ab(0), 8'h7B}, 9);
      send('{ab(0), CFG_LAST + 8'h01}, 1);
      mst_u.strt();
      mst_u.wr_byte(ab(1'b0), 8, ack);
      mst_u.wr_byte(8'h7D, 7, ack);
      mst_u.stop();
      rcv(exp_at(8'h7B));
      note("pointer");
      mst_u.strt();
      mst_u.wr_byte(ab(1'b0), 8, ack);
      mst_u.wr_byte(CMD_BLK_RD, 8, ack);
      chk_bit(ack, 1'b1);
      mst_u.strt();
      mst_u.wr_byte(ab(1'b1), 8, ack);
      mst_u.rd_byte(1'b1, rd);
      chk_byte(rd, BLK_RD_COUNT);
      mst_u.rd_byte(1'b0, rd);
      mst_u.stop();
      chk_byte(rd, exp_at(8'h7C));
      note("block read");
      send('{ab(0), CMD_EXT_ON}, 9);
      send('{ab(0), EXT_LAST, d[0]}, 9);
      send('{ab(0), CMD_EXT_OFF}, 9);
      send('{ab(0), CFG_LAST + 8'h01}, 1);
      note("pages");
      send('{ab(0), CMD_EE_ON}, 9);
      send('{ab(0), 8'h20, d[1]}, 9);
      wbusy();
      repeat (2) rdb(8'h20, d[1]);
      send('{ab(0), CMD_EE_OFF}, 9);
      send('{ab(0), CMD_EXT_ON}, 9);
      send('{ab(0), CMD_REBOOT}, 9);
      wbusy();
      send('{ab(0), CFG_LAST + 8'h01}, 1);
      send('{ab(0), 8'h20}, 9);
      rcv(d[1]);
      note("reboot");
      send('{ab(0), FLOG_CTRL_ADDR, 8'h03}, 9);
      send('{ab(0), CMD_FSTORE}, 9);
      wbusy();
      chk_byte(8'(rises), 8'h03);
      note("fault store");
      conclude();
   end
endmodule // tb_top
